// ===== rate_gen_pkg.sv
// shared constants and decoding for the serial bit rate generator
package rate_gen_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses on the apb bus)
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ----------------------------------------------------------------
  // serial_rate_divider_control fields
  // ----------------------------------------------------------------
  localparam int CTRL_W = 8;
  localparam int PRESCALE_LSB = 4;
  localparam int PRESCALE_W = 2;
  localparam int RATE_LSB = 0;
  localparam int RATE_W = 3;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] CTRL_WMASK = 8'h37;

  // ----------------------------------------------------------------
  // status fields (divider phase counters)
  // ----------------------------------------------------------------
  localparam int STAT_RATE_LSB = 0;
  localparam int STAT_FIXED_LSB = 8;
  localparam int STAT_PRE_LSB = 16;

  // ----------------------------------------------------------------
  // divider chain
  // ----------------------------------------------------------------
  localparam int PRE_W = 4;
  localparam int FIXED_W = 6;
  localparam int RDIV_W = 8;
  localparam int PERIOD_W = 20;
  localparam int FIXED_DIV = 64;
  localparam logic [5:0] FIXED_LAST = 6'(FIXED_DIV - 1);

  function automatic logic [3:0] prescaler_divisor(input logic [1:0] code);
    case (code)
      2'h0: prescaler_divisor = 4'h1;
      2'h1: prescaler_divisor = 4'h3;
      2'h2: prescaler_divisor = 4'h4;
      default: prescaler_divisor = 4'hD;
    endcase
  endfunction : prescaler_divisor

  function automatic logic [7:0] rate_divisor(input logic [2:0] code);
    rate_divisor = 8'h01 << code;
  endfunction : rate_divisor

  function automatic logic [19:0] bit_period(input logic [1:0] pcode,
                                             input logic [2:0] rcode);
    bit_period = 20'(FIXED_DIV) * 20'(prescaler_divisor(pcode)) * 20'(rate_divisor(rcode));
  endfunction : bit_period

endpackage : rate_gen_pkg

// ===== divide_stage.sv
// one modulo stage of the divider chain
`timescale 1ns/10ps
module divide_stage #(
  parameter int W = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic step,
  input wire logic [W-1:0] last,
  output logic [W-1:0] count,
  output wire logic wrap
);

  // restart masks the wrap so no stray tick escapes on a rate change
  assign wrap = step && !restart && (count == last);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count <= '0;
    end else if (restart) begin
      count <= '0;
    end else if (step) begin
      count <= wrap ? '0 : W'(count + 1'b1);
    end
  end

endmodule : divide_stage

// ===== rate_apb_regs.sv
// apb slave holding the divisor control register and status readback
`timescale 1ns/10ps
module rate_apb_regs (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] status,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [7:0] ctrl_q,
  output wire logic ctrl_wr
);

  logic hit_ctrl;
  logic hit_status;
  logic access;

  assign hit_ctrl = (paddr == rate_gen_pkg::ADDR_CTRL);
  assign hit_status = (paddr == rate_gen_pkg::ADDR_STATUS);
  assign access = psel && penable && pready;
  assign ctrl_wr = access && pwrite && hit_ctrl;

  // ----------------------------------------------------------------
  // answer: prepared in the setup cycle, shown for the one access cycle
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(hit_ctrl || hit_status);
      if (psel && !penable && !pwrite && hit_ctrl) begin
        prdata <= {24'h00_0000, ctrl_q};
      end else if (psel && !penable && !pwrite && hit_status) begin
        prdata <= status;
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

  // reserved bits are masked so they read back as zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= rate_gen_pkg::CTRL_RESET;
    end else if (ctrl_wr) begin
      ctrl_q <= pwdata[7:0] & rate_gen_pkg::CTRL_WMASK;
    end
  end

endmodule : rate_apb_regs

// ===== serial_rate_gen.sv
// serial bit rate generator: apb control, divider chain, bit rate ticks
//
// Operation
// [R01] one bit rate from the divisors feeds both receiver and transmitter
// [R02] prescale code 00,01,10,11 divides by 1,3,4,13
// [R03] reset clears the prescale select field to divide by one
// [R04] rate select field divides by two to its value; reset clears it
// [R05] bit rate is reference clock over 64 times prescale times rate divisor
// [R06] any write of the divisor fields restarts the divider chain from zero
`timescale 1ns/10ps
module serial_rate_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic rx_rate_tick,
  output logic tx_rate_tick
);

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  logic [7:0] ctrl_q;
  logic ctrl_wr;
  logic [1:0] prescale_sel;
  logic [2:0] rate_sel;
  logic [3:0] pre_last;
  logic [7:0] rate_last;
  logic [3:0] pre_count;
  logic [5:0] fixed_count;
  logic [7:0] rate_count;
  logic pre_wrap;
  logic fixed_wrap;
  logic bit_wrap;
  logic [31:0] status;

  // ----------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------
  rate_apb_regs u_regs (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .status(status),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .ctrl_q(ctrl_q),
    .ctrl_wr(ctrl_wr)
  );

  // reset value of ctrl_q zeroes both fields  // see [R03] [R04]
  assign prescale_sel = ctrl_q[rate_gen_pkg::PRESCALE_LSB +: rate_gen_pkg::PRESCALE_W];
  assign rate_sel = ctrl_q[rate_gen_pkg::RATE_LSB +: rate_gen_pkg::RATE_W];

  assign status = {12'h000, pre_count, 2'b00, fixed_count, rate_count};

  // ----------------------------------------------------------------
  // divider chain: prescaler, fixed divide by 64, rate divisor
  // ----------------------------------------------------------------
  // counters hold last = divisor - 1 so each stage divides exactly
  assign pre_last = 4'(rate_gen_pkg::prescaler_divisor(prescale_sel) - 4'h1);  // see [R02]
  assign rate_last = 8'(rate_gen_pkg::rate_divisor(rate_sel) - 8'h01);  // see [R04]

  divide_stage #(.W(rate_gen_pkg::PRE_W)) u_pre (
    .pclk(pclk),
    .presetn(presetn),
    .restart(ctrl_wr),  // see [R06]
    .step(1'b1),
    .last(pre_last),
    .count(pre_count),
    .wrap(pre_wrap)
  );

  divide_stage #(.W(rate_gen_pkg::FIXED_W)) u_fixed (
    .pclk(pclk),
    .presetn(presetn),
    .restart(ctrl_wr),  // see [R06]
    .step(pre_wrap),
    .last(rate_gen_pkg::FIXED_LAST),  // see [R05]
    .count(fixed_count),
    .wrap(fixed_wrap)
  );

  divide_stage #(.W(rate_gen_pkg::RDIV_W)) u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .restart(ctrl_wr),  // see [R06]
    .step(fixed_wrap),
    .last(rate_last),
    .count(rate_count),
    .wrap(bit_wrap)
  );

  // ----------------------------------------------------------------
  // bit rate outputs
  // ----------------------------------------------------------------
  // both halves get the very same tick, so they can never drift apart
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rx_rate_tick <= 1'b0;
      tx_rate_tick <= 1'b0;
    end else begin
      rx_rate_tick <= bit_wrap;  // see [R01]
      tx_rate_tick <= bit_wrap;  // see [R01]
    end
  end

  // ----------------------------------------------------------------
  // checking helpers
  // ----------------------------------------------------------------
  logic [19:0] gap_q;
  logic [3:0] pre_gap_q;
  logic [7:0] fixed_seen_q;
  logic out_of_reset_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 20'h00000;
    end else if (ctrl_wr || bit_wrap) begin
      gap_q <= 20'h00000;
    end else begin
      gap_q <= 20'(gap_q + 20'h00001);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_gap_q <= 4'h0;
    end else if (ctrl_wr || pre_wrap) begin
      pre_gap_q <= 4'h0;
    end else begin
      pre_gap_q <= 4'(pre_gap_q + 4'h1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fixed_seen_q <= 8'h00;
    end else if (ctrl_wr || bit_wrap) begin
      fixed_seen_q <= 8'h00;
    end else if (fixed_wrap) begin
      fixed_seen_q <= 8'(fixed_seen_q + 8'h01);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_of_reset_q <= 1'b0;
    end else begin
      out_of_reset_q <= 1'b1;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_same_rate;
    @(posedge pclk) disable iff (!presetn)
      bit_wrap |=> (rx_rate_tick && tx_rate_tick);
  endproperty
  a_same_rate: assert property (p_same_rate)  // see [R01]
    else $error("receive and transmit ticks differ");

  property p_tick_pair;
    @(posedge pclk) disable iff (!presetn)
      rx_rate_tick == tx_rate_tick;
  endproperty
  a_tick_pair: assert property (p_tick_pair)  // see [R01]
    else $error("receive tick without transmit tick");

  property p_prescale_spacing;
    @(posedge pclk) disable iff (!presetn)
      pre_wrap |-> (5'(pre_gap_q) + 5'h01) ==
        5'(rate_gen_pkg::prescaler_divisor(prescale_sel));
  endproperty
  a_prescale_spacing: assert property (p_prescale_spacing)  // see [R02]
    else $error("prescaler stage spacing wrong");

  // the gap counter stands in for a long repetition the tools would unroll
  property p_prescale_thirteen;
    @(posedge pclk) disable iff (!presetn)
      (pre_wrap && prescale_sel == 2'h3) |-> pre_gap_q == 4'hC;
  endproperty
  a_prescale_thirteen: assert property (p_prescale_thirteen)  // see [R02]
    else $error("prescale code 11 did not divide by 13");

  property p_reset_prescale;
    @(posedge pclk) disable iff (!presetn)
      !out_of_reset_q |-> (prescale_sel == 2'h0 && pre_last == 4'h0);
  endproperty
  a_reset_prescale: assert property (p_reset_prescale)  // see [R03]
    else $error("prescale select not cleared by reset");

  property p_reset_rate;
    @(posedge pclk) disable iff (!presetn)
      !out_of_reset_q |-> (rate_sel == 3'h0 && rate_last == 8'h00);
  endproperty
  a_reset_rate: assert property (p_reset_rate)  // see [R04]
    else $error("rate select not cleared by reset");

  property p_rate_stage;
    @(posedge pclk) disable iff (!presetn)
      bit_wrap |-> (9'(fixed_seen_q) + 9'h001) ==
        9'(rate_gen_pkg::rate_divisor(rate_sel));
  endproperty
  a_rate_stage: assert property (p_rate_stage)  // see [R04]
    else $error("rate divisor stage spacing wrong");

  property p_bit_period;
    @(posedge pclk) disable iff (!presetn)
      bit_wrap |-> (20'(gap_q + 20'h00001) ==
        rate_gen_pkg::bit_period(prescale_sel, rate_sel));
  endproperty
  a_bit_period: assert property (p_bit_period)  // see [R05]
    else $error("bit period not 64 times prescale times rate divisor");

  property p_restart;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> (pre_count == 4'h0 && fixed_count == 6'h00 && rate_count == 8'h00
                   && !rx_rate_tick);
  endproperty
  a_restart: assert property (p_restart)  // see [R06]
    else $error("divider chain not restarted by control write");

  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
      (psel && !penable) |=> (pready ##1 !pready);
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("apb answer not exactly one access cycle");

  property p_tick_single;
    @(posedge pclk) disable iff (!presetn)
      rx_rate_tick |=> !rx_rate_tick;
  endproperty
  a_tick_single: assert property (p_tick_single)  // see [R05]
    else $error("bit rate tick longer than one cycle");

  property p_pre_bound;
    @(posedge pclk) disable iff (!presetn)
      pre_count <= pre_last;
  endproperty
  a_pre_bound: assert property (p_pre_bound)  // see [R02]
    else $error("prescaler count beyond its last value");

  property p_rate_bound;
    @(posedge pclk) disable iff (!presetn)
      rate_count <= rate_last;
  endproperty
  a_rate_bound: assert property (p_rate_bound)  // see [R04]
    else $error("rate stage count beyond its last value");

  property p_write_prescale;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> prescale_sel ==
        $past(pwdata[rate_gen_pkg::PRESCALE_LSB +: rate_gen_pkg::PRESCALE_W]);
  endproperty
  a_write_prescale: assert property (p_write_prescale)  // see [R02]
    else $error("prescale select not taken from the write");

  property p_write_rate;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr |=> rate_sel ==
        $past(pwdata[rate_gen_pkg::RATE_LSB +: rate_gen_pkg::RATE_W]);
  endproperty
  a_write_rate: assert property (p_write_rate)  // see [R04]
    else $error("rate select not taken from the write");

  // ----------------------------------------------------------------
  // coverage of main scenarios
  // ----------------------------------------------------------------
  property p_cov_slowest;
    @(posedge pclk) disable iff (!presetn)
      bit_wrap && prescale_sel == 2'h3 && rate_sel == 3'h7;
  endproperty
  c_cov_slowest: cover property (p_cov_slowest);

  property p_cov_fastest;
    @(posedge pclk) disable iff (!presetn)
      bit_wrap ##64 bit_wrap;
  endproperty
  c_cov_fastest: cover property (p_cov_fastest);

  property p_cov_write_mid_period;
    @(posedge pclk) disable iff (!presetn)
      ctrl_wr && fixed_count != 6'h00;
  endproperty
  c_cov_write_mid_period: cover property (p_cov_write_mid_period);

  property p_cov_bad_addr;
    @(posedge pclk) disable iff (!presetn)
      pready && pslverr;
  endproperty
  c_cov_bad_addr: cover property (p_cov_bad_addr);

endmodule : serial_rate_gen

// ===== serial_baud_rate_generator_bench.sv
// self-checking bench for the serial bit rate generator
`timescale 1ns/10ps
module serial_baud_rate_generator_bench;
  // ----------------------------------------------------------------
  // clock, reset, bus signals
  // ----------------------------------------------------------------
  localparam int LIMIT = 80000;
  logic pclk;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic rx_rate_tick;
  logic tx_rate_tick;
  int err_total = 0;
  int checks_done = 0;
  int cycles = 0;
  int ph = 0;
  int n_exp = 64;
  logic tick_exp = 1'b0;
  logic [31:0] rd;
  logic er;
  serial_rate_gen serial_rate_gen_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_rate_tick(rx_rate_tick), .tx_rate_tick(tx_rate_tick)
  );
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  // ----------------------------------------------------------------
  // checking and closing
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    $display("errors=%0d checks=%0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test
  always @(posedge pclk) begin
    cycles++;
    if (cycles == LIMIT) begin
      err_total++;
      stop_test();
    end
  end
  // ----------------------------------------------------------------
  // reference model of the divider chain
  // ----------------------------------------------------------------
  function automatic int period(input logic [7:0] c);
    int pd;
    pd = (c[5:4] == 2'h0) ? 1 : (c[5:4] == 2'h1) ? 3 : (c[5:4] == 2'h2) ? 4 : 13;
    return 64 * pd * (1 << c[2:0]);
  endfunction : period
  always @(posedge pclk) begin
    if (presetn) begin
      if (psel && penable && pready && pwrite && paddr == rate_gen_pkg::ADDR_CTRL) begin
        // any control write restarts the chain and cancels a pending tick
        n_exp = period(pwdata[7:0]);
        ph = 0;
        tick_exp = 1'b0;
      end else begin
        ph++;
        tick_exp = (ph == n_exp);
        if (tick_exp) begin
          ph = 0;
        end
      end
    end
    #1;
    if (!presetn) begin
      ph = 0;
      n_exp = 64;
      tick_exp = 1'b0;
    end
    check({31'h0, rx_rate_tick}, {31'h0, tick_exp});
    check({31'h0, tx_rate_tick}, {31'h0, tick_exp});
  end
  // ----------------------------------------------------------------
  // apb master
  // ----------------------------------------------------------------
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int guard;
    guard = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      guard++;
    end while (pready !== 1'b1 && guard < 50);
    r = prdata;
    e = pslverr;
    if (guard >= 50) begin
      err_total++;
    end
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] code;
    logic [31:0] wd;
    int n;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    presetn = 1'b0;
    void'($urandom(32'h6f64950e));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rate_gen_pkg::ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h0);
    repeat (140) @(posedge pclk);
    // each nonzero prescale code, then each nonzero rate code; reserved bits randomised
    for (int i = 1; i < 11; i++) begin
      code = (i < 4) ? 8'(i << 4) : 8'(i - 3);
      wd = {24'h0, code} | ($urandom & 32'hFFFFFFC8);
      apb(1'b1, rate_gen_pkg::ADDR_CTRL, wd, rd, er);
      apb(1'b0, rate_gen_pkg::ADDR_CTRL, 32'h0, rd, er);
      check(rd, {24'h0, code});
      n = period(code);
      repeat ($urandom_range(n - 1, 1)) @(posedge pclk);
      // rewrite mid-period: the tick must slip by a full new period
      apb(1'b1, rate_gen_pkg::ADDR_CTRL, wd, rd, er);
      repeat (2 * n + 4) @(posedge pclk);
    end
    apb(1'b0, 8'h08, 32'h0, rd, er);
    check(rd, 32'h0);
    check({31'h0, er}, 32'h1);
    apb(1'b1, 8'h08, 32'h37, rd, er);
    check({31'h0, er}, 32'h1);
    apb(1'b0, rate_gen_pkg::ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h07);
    // second reset in mid-run returns both fields to divide by one
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, rate_gen_pkg::ADDR_CTRL, 32'h0, rd, er);
    check(rd, 32'h0);
    // status taken one step after a restart; a status write is ignored
    apb(1'b1, rate_gen_pkg::ADDR_CTRL, 32'h0, rd, er);
    apb(1'b0, rate_gen_pkg::ADDR_STATUS, 32'h0, rd, er);
    check(rd, 32'h0000_0100);
    apb(1'b1, rate_gen_pkg::ADDR_STATUS, 32'hFF, rd, er);
    check({31'h0, er}, 32'h0);
    repeat (140) @(posedge pclk);
    stop_test();
  end
endmodule : serial_baud_rate_generator_bench
